// [verilog/slpm_consts.svh]
// constants and bit positions for the status led pin mux
`ifndef SLPM_CONSTS_SVH
`define SLPM_CONSTS_SVH
`define SLPM_ADDR_W        4
`define SLPM_LED_CTRL_ADDR 4'h0
`define SLPM_INT_STAT_ADDR 4'h1
`define SLPM_INT_MASK_ADDR 4'h2
`define SLPM_PIN_STAT_ADDR 4'h3
`define SLPM_LED_CTRL_RST  8'h00
`define SLPM_INT_MASK_RST  4'h0
// led control field positions
`define SLPM_A_LED1_BIT    0
`define SLPM_A_LED2_BIT    1
`define SLPM_B_LED1_BIT    2
`define SLPM_B_LED2_BIT    3
`define SLPM_A_RDY_SEL_BIT 4
`define SLPM_A_ERR_SEL_BIT 5
`define SLPM_B_RDY_SEL_BIT 6
`define SLPM_B_ERR_SEL_BIT 7
// flag positions in status and mask
`define SLPM_A_RDY_FLAG    0
`define SLPM_A_ERR_FLAG    1
`define SLPM_B_RDY_FLAG    2
`define SLPM_B_ERR_FLAG    3
`endif

// [verilog/slpm_pkg.sv]
// types for the status led pin mux
package slpm_pkg;
  typedef struct packed {
    logic b_err;
    logic b_rdy;
    logic a_err;
    logic a_rdy;
  } slpm_flags_t;
  typedef struct packed {
    logic out;
    logic oe;
  } slpm_od_t;
endpackage

// [verilog/slpm_od_pin.sv]
// one open-drain dual purpose status pin
`timescale 1ns/100ps
module slpm_od_pin
  import slpm_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic     select,
  input  wire logic     flag,
  input  wire logic     led_on,
  output slpm_od_t      pin
);
  logic active;
  logic oe_r;
  assign active = select ? flag : led_on;
  // registered drive keeps the pin glitch free on select changes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= active;
    end
  end
  assign pin.out = 1'b0;
  assign pin.oe  = oe_r;
endmodule // slpm_od_pin

// [verilog/slpm_top.sv]
// status led pin mux: led control, interrupt flags and four open-drain pins
`timescale 1ns/100ps
`include "slpm_consts.svh"
module slpm_top
  import slpm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic [`SLPM_ADDR_W-1:0] addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [7:0]              rdata,
  input  wire slpm_flags_t             flag_set,
  output logic                         irq,
  output logic                         chan_a_ready_led_pin_o,
  output logic                         chan_a_ready_led_pin_oe,
  output logic                         chan_a_error_led_pin_o,
  output logic                         chan_a_error_led_pin_oe,
  output logic                         chan_b_ready_led_pin_o,
  output logic                         chan_b_ready_led_pin_oe,
  output logic                         chan_b_error_led_pin_o,
  output logic                         chan_b_error_led_pin_oe
);
  logic [7:0]  led_control_register_r;
  slpm_flags_t stat_r;
  logic [3:0]  mask_r;
  logic [7:0]  rdata_r;
  slpm_od_t    pin_a_rdy;
  slpm_od_t    pin_a_err;
  slpm_od_t    pin_b_rdy;
  slpm_od_t    pin_b_err;
  logic        stat_wr;
  logic [3:0]  pin_state;

  assign stat_wr = wr && (addr == `SLPM_INT_STAT_ADDR);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      led_control_register_r <= `SLPM_LED_CTRL_RST;
    end else if (wr && addr == `SLPM_LED_CTRL_ADDR) begin
      led_control_register_r <= wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_r <= `SLPM_INT_MASK_RST;
    end else if (wr && addr == `SLPM_INT_MASK_ADDR) begin
      mask_r <= wdata[3:0];
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~(stat_wr ? wdata[3:0] : 4'h0)) | flag_set;
    end
  end

  assign irq = |(stat_r & mask_r);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      case (addr)
        `SLPM_LED_CTRL_ADDR: rdata_r <= led_control_register_r;
        `SLPM_INT_STAT_ADDR: rdata_r <= {4'h0, stat_r};
        `SLPM_INT_MASK_ADDR: rdata_r <= {4'h0, mask_r};
        `SLPM_PIN_STAT_ADDR: rdata_r <= {4'h0, pin_state};
        default:             rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  slpm_od_pin u_a_rdy (
    .clk    (clk),
    .reset  (reset),
    .select (led_control_register_r[`SLPM_A_RDY_SEL_BIT]),
    .flag   (stat_r.a_rdy),
    .led_on (led_control_register_r[`SLPM_A_LED1_BIT]),
    .pin    (pin_a_rdy)
  );
  slpm_od_pin u_a_err (
    .clk    (clk),
    .reset  (reset),
    .select (led_control_register_r[`SLPM_A_ERR_SEL_BIT]),
    .flag   (stat_r.a_err),
    .led_on (led_control_register_r[`SLPM_A_LED2_BIT]),
    .pin    (pin_a_err)
  );
  slpm_od_pin u_b_rdy (
    .clk    (clk),
    .reset  (reset),
    .select (led_control_register_r[`SLPM_B_RDY_SEL_BIT]),
    .flag   (stat_r.b_rdy),
    .led_on (led_control_register_r[`SLPM_B_LED1_BIT]),
    .pin    (pin_b_rdy)
  );
  slpm_od_pin u_b_err (
    .clk    (clk),
    .reset  (reset),
    .select (led_control_register_r[`SLPM_B_ERR_SEL_BIT]),
    .flag   (stat_r.b_err),
    .led_on (led_control_register_r[`SLPM_B_LED2_BIT]),
    .pin    (pin_b_err)
  );

  assign pin_state = {pin_b_err.oe, pin_b_rdy.oe, pin_a_err.oe, pin_a_rdy.oe};
  assign chan_a_ready_led_pin_o  = pin_a_rdy.out;
  assign chan_a_ready_led_pin_oe = pin_a_rdy.oe;
  assign chan_a_error_led_pin_o  = pin_a_err.out;
  assign chan_a_error_led_pin_oe = pin_a_err.oe;
  assign chan_b_ready_led_pin_o  = pin_b_rdy.out;
  assign chan_b_ready_led_pin_oe = pin_b_rdy.oe;
  assign chan_b_error_led_pin_o  = pin_b_err.out;
  assign chan_b_error_led_pin_oe = pin_b_err.oe;

  sequence a_err_ind_s;
    led_control_register_r[`SLPM_A_ERR_SEL_BIT] && stat_r.a_err;
  endsequence
  a_err_ind_a: assert property (@(posedge clk) disable iff (reset)
    a_err_ind_s |=> chan_a_error_led_pin_oe)
    else $error("channel A error pin not low while flag set");
  a_err_led_a: assert property (@(posedge clk) disable iff (reset)
    !led_control_register_r[`SLPM_A_ERR_SEL_BIT]
    |=> chan_a_error_led_pin_oe == $past(led_control_register_r[`SLPM_A_LED2_BIT]))
    else $error("channel A error pin does not follow led2");
  b_rdy_ind_a: assert property (@(posedge clk) disable iff (reset)
    led_control_register_r[`SLPM_B_RDY_SEL_BIT]
    |=> chan_b_ready_led_pin_oe == $past(stat_r.b_rdy))
    else $error("channel B ready pin does not follow flag");
  b_rdy_led_a: assert property (@(posedge clk) disable iff (reset)
    !led_control_register_r[`SLPM_B_RDY_SEL_BIT]
    |=> chan_b_ready_led_pin_oe == $past(led_control_register_r[`SLPM_B_LED1_BIT]))
    else $error("channel B ready pin does not follow led1");
  b_err_ind_a: assert property (@(posedge clk) disable iff (reset)
    led_control_register_r[`SLPM_B_ERR_SEL_BIT]
    |=> chan_b_error_led_pin_oe == $past(stat_r.b_err))
    else $error("channel B error pin does not follow flag");
  b_err_led_a: assert property (@(posedge clk) disable iff (reset)
    !led_control_register_r[`SLPM_B_ERR_SEL_BIT]
    |=> chan_b_error_led_pin_oe == $past(led_control_register_r[`SLPM_B_LED2_BIT]))
    else $error("channel B error pin does not follow led2");
  a_rdy_mux_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> chan_a_ready_led_pin_oe == ($past(led_control_register_r[`SLPM_A_RDY_SEL_BIT])
      ? $past(stat_r.a_rdy) : $past(led_control_register_r[`SLPM_A_LED1_BIT])))
    else $error("channel A ready pin mux wrong");
  od_low_only_a: assert property (@(posedge clk) disable iff (reset)
    !chan_a_ready_led_pin_o && !chan_a_error_led_pin_o
    && !chan_b_ready_led_pin_o && !chan_b_error_led_pin_o)
    else $error("open-drain pin drives high");
  flag_sticky_a: assert property (@(posedge clk) disable iff (reset)
    flag_set.a_err |=> stat_r.a_err)
    else $error("event lost against clear");

  // register bus: writes land on the next edge, read data stand one cycle only
  sequence led_wr_s;
    wr && addr == `SLPM_LED_CTRL_ADDR;
  endsequence
  sequence mask_wr_s;
    wr && addr == `SLPM_INT_MASK_ADDR;
  endsequence
  sequence stat_rd_s;
    rd && addr == `SLPM_INT_STAT_ADDR;
  endsequence
  led_wr_land_a: assert property (@(posedge clk) disable iff (reset)
    led_wr_s |=> led_control_register_r == $past(wdata))
    else $error("led control write lost");
  mask_wr_land_a: assert property (@(posedge clk) disable iff (reset)
    mask_wr_s |=> mask_r == $past(wdata[3:0]))
    else $error("mask write lost");
  rd_stat_a: assert property (@(posedge clk) disable iff (reset)
    stat_rd_s |=> rdata == {4'h0, $past(stat_r)})
    else $error("status read data wrong");
  rd_led_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == `SLPM_LED_CTRL_ADDR |=> rdata == $past(led_control_register_r))
    else $error("led control read data wrong");
  rd_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == 8'h00)
    else $error("read data held past its cycle");

  // status: every event lands, a written one clears, nothing else drops
  stat_set_wins_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> (stat_r & $past(flag_set)) == $past(flag_set))
    else $error("status event lost");
  stat_w1c_a: assert property (@(posedge clk) disable iff (reset)
    stat_wr |=> (stat_r & $past(wdata[3:0]) & ~$past(flag_set)) == 4'h0)
    else $error("status bit survived its clear");
  stat_sticky_a: assert property (@(posedge clk) disable iff (reset)
    !stat_wr |=> (stat_r & $past(stat_r)) == $past(stat_r))
    else $error("status bit dropped without a clear");

  // pins answer two edges after the write or the event that causes it
  sequence a_err_led_on_s;
    led_wr_s ##0 (!wdata[`SLPM_A_ERR_SEL_BIT] && wdata[`SLPM_A_LED2_BIT]);
  endsequence
  a_err_wr_led_a: assert property (@(posedge clk) disable iff (reset)
    a_err_led_on_s |=> ##1 chan_a_error_led_pin_oe)
    else $error("channel A error led not lit after write");
  sequence b_err_evt_s;
    (led_control_register_r[`SLPM_B_ERR_SEL_BIT] && flag_set.b_err)
    ##1 led_control_register_r[`SLPM_B_ERR_SEL_BIT];
  endsequence
  b_err_evt_pin_a: assert property (@(posedge clk) disable iff (reset)
    b_err_evt_s |=> chan_b_error_led_pin_oe)
    else $error("channel B error pin missed an event");
  // in led mode a set flag must not pull the pin
  b_rdy_led_only_a: assert property (@(posedge clk) disable iff (reset)
    !led_control_register_r[`SLPM_B_RDY_SEL_BIT] && !led_control_register_r[`SLPM_B_LED1_BIT]
    && stat_r.b_rdy |=> !chan_b_ready_led_pin_oe)
    else $error("channel B ready pin driven by flag in led mode");
  a_rdy_release_a: assert property (@(posedge clk) disable iff (reset)
    (led_control_register_r[`SLPM_A_RDY_SEL_BIT] ? !stat_r.a_rdy
      : !led_control_register_r[`SLPM_A_LED1_BIT]) |=> !chan_a_ready_led_pin_oe)
    else $error("channel A ready pin not released while idle");
endmodule // slpm_top

// [test/slpm_led_model.sv]
// pull-up and led load seen by the four open-drain status pins
`timescale 1ns/100ps
module slpm_led_model (
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  output logic      [3:0] level
);
  // a released pin floats up through its resistor, never keeps its last value
  assign level = (pin_oe & pin_o) | ~pin_oe;
endmodule // slpm_led_model

// [test/tb_top.sv]
// self-checking bench for the status led pin mux
`timescale 1ns/100ps
`include "slpm_consts.svh"
module tb_top
  import slpm_pkg::*;
;
  logic        clk = 0;
  logic        reset = 1;
  logic [3:0]  addr = '0;
  logic [7:0]  wdata = '0;
  logic        wr = 0;
  logic        rd = 0;
  logic [7:0]  rdata;
  slpm_flags_t flag_set = '0;
  logic        irq;
  logic [3:0]  po;
  logic [3:0]  poe;
  logic [3:0]  level;
  int          fail_count = 0;
  int          compares = 0;
  slpm_top dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .flag_set(flag_set), .irq(irq),
    .chan_a_ready_led_pin_o(po[0]), .chan_a_ready_led_pin_oe(poe[0]),
    .chan_a_error_led_pin_o(po[1]), .chan_a_error_led_pin_oe(poe[1]),
    .chan_b_ready_led_pin_o(po[2]), .chan_b_ready_led_pin_oe(poe[2]),
    .chan_b_error_led_pin_o(po[3]), .chan_b_error_led_pin_oe(poe[3]));
  slpm_led_model load_u (.pin_o(po), .pin_oe(poe), .level(level));
  initial forever #4 clk = ~clk;
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_chk(string name, logic [3:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(name, rdata, exp);
  endtask
  task automatic pulse(logic [3:0] v);
    @(posedge clk);
    flag_set <= v;
    @(posedge clk);
    flag_set <= '0;
  endtask
  // pins are registered, so allow the extra cycle before looking
  task automatic pins_chk(logic [3:0] act);
    @(posedge clk);
    @(posedge clk);
    #1 chk("pin level", {4'h0, level}, {4'h0, ~act});
    chk("pin drive", {4'h0, po}, 8'h00);
    rd_chk("pin state", `SLPM_PIN_STAT_ADDR, {4'h0, act});
  endtask
  task automatic t_reset();
    rd_chk("led ctrl", `SLPM_LED_CTRL_ADDR, 8'h00);
    rd_chk("status", `SLPM_INT_STAT_ADDR, 8'h00);
    rd_chk("mask", `SLPM_INT_MASK_ADDR, 8'h00);
    rd_chk("unmapped", 4'h4, 8'h00);
    pins_chk(4'h0);
    $display("reset test done");
  endtask
  task automatic t_led();
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SLPM_LED_CTRL_ADDR, 8'(1 << i));
      rd_chk("led ctrl", `SLPM_LED_CTRL_ADDR, 8'(1 << i));
      pins_chk(4'(1 << i));
    end
    $display("led test done");
  endtask
  task automatic t_ind();
    // led bits on too: in indicator mode they must not reach the pin
    wr_reg(`SLPM_LED_CTRL_ADDR, 8'hff);
    pins_chk(4'h0);
    for (int i = 0; i < 4; i++) begin
      pulse(4'(1 << i));
      pins_chk(4'(1 << i));
      rd_chk("status", `SLPM_INT_STAT_ADDR, 8'(1 << i));
      wr_reg(`SLPM_INT_STAT_ADDR, 8'(1 << i));
      pins_chk(4'h0);
    end
    $display("indicator test done");
  endtask
  task automatic t_irq();
    wr_reg(`SLPM_INT_MASK_ADDR, 8'h02);
    rd_chk("mask", `SLPM_INT_MASK_ADDR, 8'h02);
    pulse(4'h1);
    pins_chk(4'h1);
    chk("irq masked", {7'h0, irq}, 8'h00);
    pulse(4'h2);
    pins_chk(4'h3);
    chk("irq", {7'h0, irq}, 8'h01);
    wr_reg(`SLPM_INT_STAT_ADDR, 8'h03);
    pins_chk(4'h0);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    $display("irq test done");
  endtask
  // flags raised while in led mode must stay off the pins until selected
  task automatic t_mix();
    wr_reg(`SLPM_LED_CTRL_ADDR, 8'h00);
    pulse(4'hf);
    pins_chk(4'h0);
    wr_reg(`SLPM_LED_CTRL_ADDR, 8'h50);
    pins_chk(4'h5);
    wr_reg(`SLPM_INT_STAT_ADDR, 8'h01);
    pins_chk(4'h4);
    wr_reg(`SLPM_LED_CTRL_ADDR, 8'ha0);
    pins_chk(4'ha);
    wr_reg(4'h4, 8'hff);
    rd_chk("led ctrl", `SLPM_LED_CTRL_ADDR, 8'ha0);
    @(posedge clk);
    #1 chk("rdata idle", rdata, 8'h00);
    rd_chk("mask", `SLPM_INT_MASK_ADDR, 8'h02);
    wr_reg(`SLPM_INT_STAT_ADDR, 8'h0f);
    rd_chk("status", `SLPM_INT_STAT_ADDR, 8'h00);
    pins_chk(4'h0);
    $display("mode mix test done");
  endtask
  // a clear written in the cycle of a new event must not lose the event
  task automatic t_collide();
    pulse(4'h1);
    @(posedge clk);
    wr <= 1;
    addr <= `SLPM_INT_STAT_ADDR;
    wdata <= 8'h03;
    flag_set <= 4'h2;
    @(posedge clk);
    wr <= 0;
    flag_set <= '0;
    rd_chk("status collide", `SLPM_INT_STAT_ADDR, 8'h02);
    wr_reg(`SLPM_INT_STAT_ADDR, 8'h02);
    rd_chk("status cleared", `SLPM_INT_STAT_ADDR, 8'h00);
    $display("collision test done");
  endtask
  task automatic t_midreset();
    wr_reg(`SLPM_LED_CTRL_ADDR, 8'h0f);
    wr_reg(`SLPM_INT_MASK_ADDR, 8'h0f);
    pulse(4'hf);
    pins_chk(4'hf);
    chk("irq before reset", {7'h0, irq}, 8'h01);
    @(posedge clk);
    reset <= 1;
    @(posedge clk);
    #1 chk("pins in reset", {4'h0, poe}, 8'h00);
    chk("irq in reset", {7'h0, irq}, 8'h00);
    @(posedge clk);
    reset <= 0;
    t_reset();
    $display("mid-run reset test done");
  endtask
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    t_reset();
    t_led();
    t_ind();
    t_irq();
    t_mix();
    t_collide();
    t_midreset();
    results();
  end
  // whole run is a few hundred cycles
  initial begin
    #40000;
    fail_count++;
    results();
  end
endmodule // tb_top
